// >>> logic/csio_pkg.sv
// Shared constants, register map and types of the clock-synchronous serial channel
package csio_pkg;
    // Register byte addresses (Avalon word aligned)
    localparam logic [3:0] ADDR_CONTROL_ZERO = 4'h0; // serial_control_zero
    localparam logic [3:0] ADDR_CONTROL_ONE = 4'h4; // serial_control_one
    localparam logic [3:0] ADDR_TRANSMIT = 4'h8; // transmit_buffer
    localparam logic [3:0] ADDR_RECEIVE = 4'hc; // receive_buffer
    // serial_control_zero fields
    localparam int C0_INTCLK = 0; // 1 internal shift clock
    localparam int C0_POLARITY = 1; // clock_polarity_select
    localparam int C0_RTS_SEL = 2; // 1 request-to-send function
    localparam int C0_CTS_SEL = 3; // 1 clear-to-send function
    localparam int C0_NMI_CUT = 4; // nmi_cutoff_enable
    localparam int C0_SMART = 5; // smart-card mode
    // serial_control_one fields
    localparam int C1_TX_EN = 0; // transmit_enable_bit
    localparam int C1_TX_EMPTY = 1; // transmit_buffer_empty_flag (read only)
    localparam int C1_RX_EN = 2; // receive_enable_bit
    localparam int C1_RX_FULL = 3; // receive_buffer_full_flag (read only)
    localparam int C1_IRQ_SRC = 4; // transmit_irq_source_select
    localparam int C1_ERR_OUT = 5; // error_signal_output_enable
    localparam int C1_TX_IRQ = 6; // transmit interrupt_request_flag, write 0 clears
    localparam int C1_RX_IRQ = 7; // receive interrupt_request_flag, write 0 clears
    // receive_buffer fields
    localparam int RB_OVERRUN = 8; // overrun_error_flag
    // Reset values
    localparam logic [5:0] CONTROL_ZERO_RESET = 6'h00;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    // Bits per transfer and internal clock half period in mclk cycles
    localparam int FRAME_BITS = 8;
    localparam logic [3:0] FRAME_BITS_M1 = 4'h7;
    localparam int HALF_PERIOD_NS = 80;
    localparam int CLK_NS = 10;
    localparam logic [7:0] HALF_CYCLES = 8'((HALF_PERIOD_NS + CLK_NS - 1) / CLK_NS);

    typedef struct packed {
        logic read;
        logic write;
        logic [3:0] address;
        logic [31:0] writedata;
    } bus_req_t;

    typedef struct packed {
        logic out; // level driven
        logic oe; // high while driving
    } pin_drive_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SHIFT = 3'b010,
        ST_DONE = 3'b100
    } shift_state_t;
endpackage : csio_pkg

// >>> logic/pin_sync.sv
// Two-stage synchroniser for one pin input
`timescale 1ns/1ps
module pin_sync (
    input wire logic mclk, // System clock
    input wire logic srst, // Sync reset
    input wire logic pinIn, // Asynchronous level
    output logic syncOut // Synchronised level
);
    logic stage1;
    logic next_stage1;
    logic next_syncOut;

    // First stage only feeds the second
    always_comb begin
        next_stage1 = pinIn;
        next_syncOut = stage1;
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            stage1 <= 1'b1;
            syncOut <= 1'b1;
        end else begin
            stage1 <= next_stage1;
            syncOut <= next_syncOut;
        end
    end
endmodule : pin_sync

// >>> logic/clock_sync_serial_port.sv
// Clock-synchronous serial channel with Avalon-MM register slave
//
// Our own choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
// Behaviour
// - With external clock and request-to-send on, the request output goes low when ready to receive and high when reception starts.
// - With internal clock the request-to-send function leaves the request output untouched.
// - With NMI cutoff enabled and NMI low, request-to-send and shift clock pins go high impedance.
// - Polarity 0 launches data on falling and samples on rising edges; polarity 1 swaps them.
// - External-clock transmit starts only with transmit enabled, buffer full, clear-to-send low if used, clock idle.
// - The shift clock comes only from transmitter activity; dummy data goes out while receiving.
// - Internal clock starts once transmit is enabled and a byte is written to the transmit buffer.
// - With external clock, shifting proceeds only on clock pulses from the peer.
// - A new byte arriving while the receive buffer is full sets the overrun flag.
// - An overrun leaves the receive interrupt request flag unchanged.
// - External-clock receive starts only with receive and transmit enabled, buffer full, clock idle.
// - In smart-card mode setting both transmit-complete source and error output bits raises a transmit request.
module clock_sync_serial_port (
    input wire logic mclk, // System clock, 100 MHz
    input wire logic srst, // Sync reset, active high
    input wire logic [3:0] avsAddress, // Byte address
    input wire logic avsRead, // Read strobe
    input wire logic avsWrite, // Write strobe
    input wire logic [31:0] avsWritedata, // Write data
    input wire logic [3:0] avsByteenable, // Byte lanes
    output logic [31:0] avsReaddata, // Read data
    output logic avsWaitrequest, // Stall
    input wire logic serialClkIn, // Shift clock pin input
    output logic serialClkOut, // Shift clock pin output
    output logic serialClkOe, // Shift clock drive enable
    output logic serialDataOut, // serial_data_out_pin
    input wire logic serialDataIn, // Receive data pin
    output logic rtsOut, // Request-to-send level
    output logic rtsOe, // Request-to-send drive enable
    input wire logic ctsIn, // Clear-to-send, low active
    input wire logic nmiIn, // NMI, low active
    output logic txIrq, // Transmit interrupt_request_flag
    output logic rxIrq // Receive interrupt_request_flag
);
    import csio_pkg::*;

    logic clkSync, dataSync, ctsSync, nmiSync;
    logic [5:0] control0, next_control0;
    logic txEn, next_txEn, rxEn, next_rxEn, irqSrc, next_irqSrc, errOut, next_errOut;
    logic txEmpty, next_txEmpty, rxFull, next_rxFull, overrun, next_overrun;
    logic txIrqR, next_txIrqR, rxIrqR, next_rxIrqR;
    logic [7:0] txBuf, next_txBuf, rxBuf, next_rxBuf;
    logic [7:0] shiftReg, next_shiftReg;
    logic [3:0] bitCount, next_bitCount;
    logic [7:0] divCount, next_divCount;
    logic clkPrev, next_clkPrev, genClk, next_genClk, dataOut, next_dataOut;
    logic rxActive, next_rxActive, waitDone, next_waitDone;
    logic [31:0] next_readdata;
    shift_state_t state, next_state;
    logic internalClk, polarity, idleLevel, launchEdge, sampleEdge, clkLevel;
    logic startOk, frameDone, wrHit, rdHit;

    // Input pins cross into mclk before use
    pin_sync syncClk (.mclk(mclk), .srst(srst), .pinIn(serialClkIn), .syncOut(clkSync));
    pin_sync syncData (.mclk(mclk), .srst(srst), .pinIn(serialDataIn), .syncOut(dataSync));
    pin_sync syncCts (.mclk(mclk), .srst(srst), .pinIn(ctsIn), .syncOut(ctsSync));
    pin_sync syncNmi (.mclk(mclk), .srst(srst), .pinIn(nmiIn), .syncOut(nmiSync));

    // Mode decode
    always_comb begin
        internalClk = control0[C0_INTCLK];
        polarity = control0[C0_POLARITY];
        idleLevel = ~polarity; // Polarity 0 idles high
        clkLevel = internalClk ? genClk : clkSync;
        // Launch on falling for 0, rising for 1; sample on the other edge
        launchEdge = (clkPrev != clkLevel) && (clkLevel == polarity);
        sampleEdge = (clkPrev != clkLevel) && (clkLevel != polarity);
        frameDone = sampleEdge && (bitCount == FRAME_BITS_M1);
        wrHit = avsWrite && !avsWaitrequest;
        rdHit = avsRead && !avsWaitrequest;
    end

    // Start condition: transmitter drives every transfer, receive included
    always_comb begin
        startOk = txEn && !txEmpty;
        if (!internalClk) begin
            // External clock must idle and clear-to-send be low if used
            startOk = startOk && (clkSync == idleLevel)
                && !(control0[C0_CTS_SEL] && ctsSync);
        end
    end

    // Shift engine next state
    always_comb begin
        next_state = state;
        next_shiftReg = shiftReg;
        next_bitCount = bitCount;
        next_divCount = divCount;
        next_genClk = genClk;
        next_clkPrev = clkLevel;
        next_dataOut = dataOut;
        next_rxActive = rxActive;
        case (state)
            ST_IDLE: begin
                next_genClk = idleLevel;
                next_divCount = BYTE_RESET;
                next_bitCount = 4'h0;
                if (startOk) begin
                    next_state = ST_SHIFT;
                    next_shiftReg = txBuf; // Dummy byte when only receiving
                    next_dataOut = txBuf[0];
                    next_rxActive = rxEn;
                end
            end
            ST_SHIFT: begin
                // Internal divider toggles the clock; external waits on the peer
                if (internalClk) begin
                    if (divCount == HALF_CYCLES - 8'h01) begin
                        next_divCount = BYTE_RESET;
                        next_genClk = ~genClk;
                    end else begin
                        next_divCount = divCount + 8'h01;
                    end
                end
                if (sampleEdge) begin
                    next_shiftReg = {dataSync, shiftReg[7:1]};
                    next_bitCount = bitCount + 4'h1;
                end
                if (launchEdge && bitCount != 4'h0) begin
                    next_dataOut = shiftReg[0];
                end
                if (frameDone) begin
                    next_state = ST_DONE;
                end
            end
            ST_DONE: begin
                // Let the clock return to idle before the next frame
                next_genClk = idleLevel;
                next_state = ST_IDLE;
                next_rxActive = 1'b0;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            state <= ST_IDLE;
            shiftReg <= BYTE_RESET;
            bitCount <= 4'h0;
            divCount <= BYTE_RESET;
            genClk <= 1'b1;
            clkPrev <= 1'b1;
            dataOut <= 1'b1;
            rxActive <= 1'b0;
        end else begin
            state <= next_state;
            shiftReg <= next_shiftReg;
            bitCount <= next_bitCount;
            divCount <= next_divCount;
            genClk <= next_genClk;
            clkPrev <= next_clkPrev;
            dataOut <= next_dataOut;
            rxActive <= next_rxActive;
        end
    end

    // Register file next values; hardware sets win over software clears
    always_comb begin
        next_control0 = control0;
        next_txEn = txEn;
        next_rxEn = rxEn;
        next_irqSrc = irqSrc;
        next_errOut = errOut;
        next_txEmpty = txEmpty;
        next_txBuf = txBuf;
        next_rxFull = rxFull;
        next_rxBuf = rxBuf;
        next_overrun = overrun;
        next_txIrqR = txIrqR;
        next_rxIrqR = rxIrqR;
        next_waitDone = (avsRead || avsWrite) && !waitDone;
        if (wrHit && avsByteenable[0]) begin
            case (avsAddress)
                ADDR_CONTROL_ZERO: next_control0 = avsWritedata[5:0];
                ADDR_CONTROL_ONE: begin
                    next_txEn = avsWritedata[C1_TX_EN];
                    next_rxEn = avsWritedata[C1_RX_EN];
                    next_irqSrc = avsWritedata[C1_IRQ_SRC];
                    next_errOut = avsWritedata[C1_ERR_OUT];
                    if (!avsWritedata[C1_TX_IRQ]) next_txIrqR = 1'b0;
                    if (!avsWritedata[C1_RX_IRQ]) next_rxIrqR = 1'b0;
                end
                ADDR_TRANSMIT: begin
                    next_txBuf = avsWritedata[7:0];
                    next_txEmpty = 1'b0;
                end
                default: begin
                end
            endcase
        end
        // Reading the receive buffer frees it and clears overrun
        if (rdHit && avsAddress == ADDR_RECEIVE) begin
            next_rxFull = 1'b0;
            next_overrun = 1'b0;
        end
        // Buffer moves into the shifter at frame start
        if (state == ST_IDLE && startOk) begin
            next_txEmpty = 1'b1;
        end
        if (frameDone && rxActive) begin
            if (rxFull) begin
                next_overrun = 1'b1; // Buffer contents undefined, keep new byte
                next_rxFull = 1'b1; // Set wins over a read in the same cycle
                next_rxBuf = {dataSync, shiftReg[7:1]};
                // Receive request flag left alone
            end else begin
                next_rxBuf = {dataSync, shiftReg[7:1]};
                next_rxFull = 1'b1;
                next_rxIrqR = 1'b1;
            end
        end
        if (frameDone && irqSrc) begin
            next_txIrqR = 1'b1;
        end
        // Smart-card quirk: the two bits becoming both one, whichever was set last, raises a request
        if (control0[C0_SMART] && next_irqSrc && next_errOut && !(irqSrc && errOut)) begin
            next_txIrqR = 1'b1;
        end
        next_readdata = 32'h0;
        case (avsAddress)
            ADDR_CONTROL_ZERO: next_readdata = {26'h0, control0};
            ADDR_CONTROL_ONE: next_readdata = {24'h0, rxIrqR, txIrqR, errOut, irqSrc,
                rxFull, rxEn, txEmpty, txEn};
            ADDR_RECEIVE: next_readdata = {23'h0, overrun, rxBuf};
            default: next_readdata = 32'h0; // Unmapped reads zero
        endcase
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            control0 <= CONTROL_ZERO_RESET;
            txEn <= 1'b0;
            rxEn <= 1'b0;
            irqSrc <= 1'b0;
            errOut <= 1'b0;
            txEmpty <= 1'b1;
            txBuf <= BYTE_RESET;
            rxFull <= 1'b0;
            rxBuf <= BYTE_RESET;
            overrun <= 1'b0;
            txIrqR <= 1'b0;
            rxIrqR <= 1'b0;
            waitDone <= 1'b0;
            avsReaddata <= 32'h0;
        end else begin
            control0 <= next_control0;
            txEn <= next_txEn;
            rxEn <= next_rxEn;
            irqSrc <= next_irqSrc;
            errOut <= next_errOut;
            txEmpty <= next_txEmpty;
            txBuf <= next_txBuf;
            rxFull <= next_rxFull;
            rxBuf <= next_rxBuf;
            overrun <= next_overrun;
            txIrqR <= next_txIrqR;
            rxIrqR <= next_rxIrqR;
            waitDone <= next_waitDone;
            avsReaddata <= next_readdata;
        end
    end

    // One wait state gives registered read data
    assign avsWaitrequest = (avsRead || avsWrite) && !waitDone;

    // Pin drivers
    always_comb begin
        serialDataOut = dataOut;
        txIrq = txIrqR;
        rxIrq = rxIrqR;
        serialClkOut = genClk;
        serialClkOe = internalClk && !(control0[C0_NMI_CUT] && !nmiSync);
        // Low when ready to receive, high once a frame runs
        rtsOut = internalClk || !(rxEn && state == ST_IDLE && !rxFull); // Held high
        rtsOe = control0[C0_RTS_SEL] && !internalClk
            && !(control0[C0_NMI_CUT] && !nmiSync);
    end
endmodule : clock_sync_serial_port

// >>> tb/csio_asserts.sv
// Port-level checker for the serial channel, bound onto its top module
`timescale 1ns/1ps
module csio_asserts
    import csio_pkg::*;
(
    input wire logic mclk, // System clock
    input wire logic srst, // Sync reset
    input wire logic [3:0] avsAddress, // Byte address
    input wire logic avsRead, // Read strobe
    input wire logic avsWrite, // Write strobe
    input wire logic [31:0] avsWritedata, // Write data
    input wire logic avsWaitrequest, // Stall
    input wire logic serialClkOut, // Shift clock level
    input wire logic serialClkOe, // Shift clock enable
    input wire logic serialDataOut, // Data out
    input wire logic rtsOut, // Request-to-send level
    input wire logic rtsOe, // Request-to-send enable
    input wire logic nmiIn, // NMI, low active
    input wire logic txIrq, // Transmit request
    input wire logic rxIrq // Receive request
);
    logic [5:0] ctlZero;
    logic [1:0] irqBits;
    logic [5:0] next_ctlZero;
    logic [1:0] next_irqBits;
    // Shadow of control fields, taken only when a write completes
    always_comb begin
        next_ctlZero = ctlZero;
        next_irqBits = irqBits;
        if (avsWrite && !avsWaitrequest && avsAddress == ADDR_CONTROL_ZERO) begin
            next_ctlZero = avsWritedata[5:0];
        end
        if (avsWrite && !avsWaitrequest && avsAddress == ADDR_CONTROL_ONE) begin
            next_irqBits = avsWritedata[C1_ERR_OUT:C1_IRQ_SRC];
        end
        if (srst) begin
            next_ctlZero = CONTROL_ZERO_RESET;
            next_irqBits = 2'h0;
        end
    end
    always_ff @(posedge mclk) begin
        ctlZero <= next_ctlZero;
        irqBits <= next_irqBits;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    // Pin cutoff lags the NMI input by the two synchroniser stages
    a_nmi_cutoff: assert property ((ctlZero[C0_NMI_CUT] && !nmiIn) [*4] |-> !rtsOe && !serialClkOe)
        else $error("request or clock pin still driven under NMI cutoff");
    a_rts_internal: assert property (ctlZero[C0_INTCLK] && $past(ctlZero[C0_INTCLK]) |-> $stable(rtsOut))
        else $error("request output moved with internal clock");
    a_ext_nodrive: assert property (!ctlZero[C0_INTCLK] && !$past(ctlZero[C0_INTCLK]) |-> !serialClkOe)
        else $error("shift clock driven in external mode");
    a_half_period: assert property (serialClkOe && $changed(serialClkOut) |=> $stable(serialClkOut) [*7])
        else $error("internal shift clock half period short");
    a_sample_stable: assert property (serialClkOe && $changed(serialClkOut)
        && (serialClkOut ^ ctlZero[C0_POLARITY]) |-> $stable(serialDataOut))
        else $error("data out moved on the sampling edge");
    a_bus_wait: assert property ($rose(avsRead || avsWrite) |-> avsWaitrequest ##1 !avsWaitrequest)
        else $error("wait state count wrong");
    a_reset_quiet: assert property ($fell(srst) |-> serialDataOut && !serialClkOe && !rtsOe && !txIrq && !rxIrq)
        else $error("outputs not idle after reset");
    a_smart_irq: assert property (ctlZero[C0_SMART] && irqBits == 2'h3 && $past(irqBits) != 2'h3
        |-> ##[0:3] txIrq)
        else $error("smart-card transmit request missing");
    c_rx_done: cover property ($rose(rxIrq));
    c_tx_irq: cover property ($rose(txIrq));
    c_cutoff: cover property (ctlZero[C0_NMI_CUT] && !nmiIn && !rtsOe);
endmodule : csio_asserts

bind clock_sync_serial_port csio_asserts i_chk (.mclk(mclk), .srst(srst), .avsAddress(avsAddress),
    .avsRead(avsRead), .avsWrite(avsWrite), .avsWritedata(avsWritedata),
    .avsWaitrequest(avsWaitrequest), .serialClkOut(serialClkOut), .serialClkOe(serialClkOe),
    .serialDataOut(serialDataOut), .rtsOut(rtsOut), .rtsOe(rtsOe), .nmiIn(nmiIn),
    .txIrq(txIrq), .rxIrq(rxIrq));

// >>> tb/serial_peer.sv
// Behavioural far-end serial device: drives or follows the shift clock
`timescale 1ns/1ps
module serial_peer (
    input wire logic lineClk, // Clock level on the wire
    input wire logic polarity, // Low: sample on rise
    input wire logic serialDataOut, // Channel data towards us
    output logic extClk, // Clock we drive in external mode
    output logic dataLine // Our data towards the channel
);
    logic [7:0] txSr;
    logic [7:0] got;
    int idx;
    initial begin
        extClk = 1'b1;
        dataLine = 1'b0;
        txSr = 8'h00;
        got = 8'h00;
        idx = 8;
    end
    // Load one byte; arming late keeps mode switches from counting as edges
    task automatic arm(input logic [7:0] b);
        txSr = b;
        idx = 0;
        dataLine = b[0];
    endtask : arm
    // Eight pulses from the idle level, only when asked for
    task automatic pulses(input int halfNs);
        #3; // Keep link edges off the system clock edge
        repeat (16) begin
            #(halfNs);
            extClk = ~extClk;
        end
    endtask : pulses
    // Launch on one edge, sample on the other, LSB first
    always @(lineClk) begin
        if (idx < 8) begin
            if (lineClk ^ polarity) begin
                got[idx] = serialDataOut;
                idx++;
                if (idx == 8) begin
                    dataLine <= #40 ~dataLine; // Released line goes stale only after hold time
                end
            end else begin
                dataLine = txSr[idx];
            end
        end
    end
endmodule : serial_peer

// >>> tb/tb.sv
// Self-checking bench for the clock-synchronous serial channel
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_fail++; $display("Error at %0t: got %h want %h", $time, (a), (b)); end end
module tb;
    import csio_pkg::*;
    typedef struct packed {
        logic [31:0] val;
        logic [31:0] mask;
    } note_t;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic [3:0] avsAddress = 4'h0;
    logic avsRead = 1'b0;
    logic avsWrite = 1'b0;
    logic [31:0] avsWritedata = 32'h0;
    logic [31:0] avsReaddata;
    logic avsWaitrequest, serialClkIn, serialClkOut, serialClkOe, serialDataOut, serialDataIn;
    logic rtsOut, rtsOe, txIrq, rxIrq, extClk;
    logic ctsIn = 1'b0;
    logic nmiIn = 1'b1;
    logic pol = 1'b0;
    logic [7:0] b0, b1;
    int n_fail = 0;
    int comparisons = 0;
    int cyc = 0;
    note_t notes[$];
    note_t n;
    always #5 mclk = ~mclk;
    // Wire level: the channel drives the clock only while enabled
    assign serialClkIn = serialClkOe ? serialClkOut : extClk;
    clock_sync_serial_port i_dut (.mclk(mclk), .srst(srst), .avsAddress(avsAddress),
        .avsRead(avsRead), .avsWrite(avsWrite), .avsWritedata(avsWritedata),
        .avsByteenable(4'hf), .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest),
        .serialClkIn(serialClkIn), .serialClkOut(serialClkOut), .serialClkOe(serialClkOe),
        .serialDataOut(serialDataOut), .serialDataIn(serialDataIn), .rtsOut(rtsOut),
        .rtsOe(rtsOe), .ctsIn(ctsIn), .nmiIn(nmiIn), .txIrq(txIrq), .rxIrq(rxIrq));
    serial_peer i_peer (.lineClk(serialClkIn), .polarity(pol), .serialDataOut(serialDataOut),
        .extClk(extClk), .dataLine(serialDataIn));
    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : report_and_stop
    // Request held until waitrequest is seen low, then one idle cycle
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        avsAddress <= a;
        avsWritedata <= d;
        avsWrite <= wr;
        avsRead <= !wr;
        // Held until the rising edge that sees waitrequest low; hang guard ends a stall
        do begin
            @(posedge mclk);
        end while (avsWaitrequest !== 1'b0);
        avsRead <= 1'b0;
        avsWrite <= 1'b0;
        @(posedge mclk);
    endtask : bus
    task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
        notes.push_back('{e, m});
        bus(1'b0, a, 32'h0);
    endtask : rd
    // One byte each way; the byte written to the transmit buffer is checked at the peer
    task automatic xfer(input logic [7:0] toDev, input logic [7:0] toPeer);
        int t;
        t = 0;
        i_peer.arm(toDev);
        bus(1'b1, ADDR_TRANSMIT, {24'h0, toPeer});
        while (i_peer.idx != 8 && t < 500) begin
            @(posedge mclk);
            t++;
        end
        repeat (4) @(posedge mclk);
        `CHK(i_peer.got, toPeer)
    endtask : xfer
    // Completed reads meet the oldest note, read data settled
    always @(posedge mclk) begin
        if (avsRead && avsWaitrequest === 1'b0) begin
            n = notes.pop_front();
            `CHK(avsReaddata & n.mask, n.val)
        end
    end
    // Hang guard
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            report_and_stop();
        end
    end
    initial begin
        void'($urandom(47));
        repeat (8) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        rd(ADDR_CONTROL_ZERO, 32'h0, '1);
        rd(ADDR_CONTROL_ONE, 32'h2, '1);
        bus(1'b1, 4'h2, 32'hff);
        rd(4'h2, 32'h0, '1);
        // Internal clock in both polarities, request function selected
        for (int p = 0; p < 2; p++) begin
            pol = p[0];
            bus(1'b1, ADDR_CONTROL_ZERO, {29'h0, 1'b1, pol, 1'b1});
            bus(1'b1, ADDR_CONTROL_ONE, 32'h5);
            b0 = 8'($urandom);
            b1 = 8'($urandom);
            xfer(b0, b1);
            `CHK(rxIrq, 1'b1)
            rd(ADDR_RECEIVE, {24'h0, b0}, '1);
            bus(1'b1, ADDR_CONTROL_ONE, 32'h5);
        end
        // Second byte lands on an unread one
        xfer(8'($urandom), 8'h3c);
        bus(1'b1, ADDR_CONTROL_ONE, 32'h5);
        xfer(8'hc3, 8'h5a);
        `CHK(rxIrq, 1'b0)
        rd(ADDR_RECEIVE, 32'h100, 32'h100);
        rd(ADDR_RECEIVE, 32'h0, 32'h100);
        // External clock with both handshakes; clear-to-send held off first
        pol = 1'b0;
        bus(1'b1, ADDR_CONTROL_ZERO, 32'hc);
        ctsIn <= 1'b1;
        i_peer.arm(b1);
        bus(1'b1, ADDR_TRANSMIT, {24'h0, b0});
        repeat (4) @(posedge mclk);
        `CHK({rtsOe, rtsOut}, 2'b10)
        i_peer.pulses(80);
        @(posedge mclk);
        rd(ADDR_CONTROL_ONE, 32'h5, '1);
        ctsIn <= 1'b0;
        i_peer.arm(b1);
        @(posedge mclk);
        fork
            i_peer.pulses(80);
            begin
                repeat (40) @(posedge mclk);
                `CHK(rtsOut, 1'b1)
            end
        join
        repeat (6) @(posedge mclk);
        `CHK(i_peer.got, b0)
        rd(ADDR_RECEIVE, {24'h0, b1}, '1);
        // NMI cutoff of the request and shift clock pins
        bus(1'b1, ADDR_CONTROL_ZERO, 32'h14);
        nmiIn <= 1'b0;
        repeat (5) @(posedge mclk);
        `CHK({rtsOe, serialClkOe}, 2'b00)
        bus(1'b1, ADDR_CONTROL_ZERO, 32'h11);
        `CHK(serialClkOe, 1'b0)
        nmiIn <= 1'b1;
        repeat (5) @(posedge mclk);
        `CHK(serialClkOe, 1'b1)
        // Smart-card transmit request, then cleared by software
        bus(1'b1, ADDR_CONTROL_ZERO, 32'h20);
        bus(1'b1, ADDR_CONTROL_ONE, 32'h30);
        `CHK(txIrq, 1'b1)
        bus(1'b1, ADDR_CONTROL_ONE, 32'h30);
        `CHK(txIrq, 1'b0)
        repeat (4) @(posedge mclk);
        report_and_stop();
    end
endmodule : tb
